// ### hw/jcp_pkg.sv
// package: constants and types shared by the configuration port
package jcp_pkg;
  localparam int IR_W      = 5;
  localparam int ID_W      = 32;
  localparam int CFG_W     = 109;
  localparam int CONV_W    = 8;
  localparam int CLK_NS    = 4;
  // operation times, microseconds; defaults only
  localparam int T_PROG_US = 10000;
  localparam int T_ERASE_US = 10000;
  localparam int T_CAL_US  = 5000;
  // least times round up to whole clocks
  localparam int PROG_CYC_DEF  = (T_PROG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC_DEF = (T_ERASE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CAL_CYC_DEF   = (T_CAL_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] TLR_STEPS = 3'h5;

  localparam logic [IR_W-1:0] IR_EXTEST        = 5'h00;
  localparam logic [IR_W-1:0] IR_SEL_CFG       = 5'h01;
  localparam logic [IR_W-1:0] IR_CFG_ERASE     = 5'h02;
  localparam logic [IR_W-1:0] IR_CFG_VERIFY    = 5'h03;
  localparam logic [IR_W-1:0] IR_CFG_PROG      = 5'h04;
  localparam logic [IR_W-1:0] IR_IDCODE        = 5'h0D;
  localparam logic [IR_W-1:0] IR_CAL_START     = 5'h10;
  localparam logic [IR_W-1:0] IR_CONV_ERASE    = 5'h11;
  localparam logic [IR_W-1:0] IR_CONV_VERIFY   = 5'h12;
  localparam logic [IR_W-1:0] IR_CONV_PROG     = 5'h13;
  localparam logic [IR_W-1:0] IR_SEL_CONV      = 5'h14;
  localparam logic [IR_W-1:0] IR_SAMPLE        = 5'h1E;
  localparam logic [IR_W-1:0] IR_BYPASS        = 5'h1F;

  typedef enum logic [3:0] {
    ST_TLR   = 4'h0, ST_RTI   = 4'h1, ST_SELDR = 4'h3, ST_CAPDR = 4'h2,
    ST_SHDR  = 4'h6, ST_EX1DR = 4'h7, ST_PDR   = 4'h5, ST_EX2DR = 4'h4,
    ST_UPDR  = 4'hC, ST_SELIR = 4'hD, ST_CAPIR = 4'hF, ST_SHIR  = 4'hE,
    ST_EX1IR = 4'hA, ST_PIR   = 4'hB, ST_EX2IR = 4'h9, ST_UPIR  = 4'h8
  } jcp_tap_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0, OP_PROG = 2'h1, OP_ERASE = 2'h3, OP_CAL = 2'h2
  } jcp_op_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jcp_pins_t;

  typedef struct packed {
    logic outputs_zero;
    logic outputs_vcom;
    logic inputs_off;
    logic suspend;
  } jcp_analog_t;
endpackage : jcp_pkg

// ### hw/jcp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module jcp_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule : jcp_sync

// ### hw/jcp_tap_fsm.sv
// sixteen-state test access controller
`timescale 1ns/1ns
module jcp_tap_fsm import jcp_pkg::*; (
  input  wire logic     clk,
  input  wire logic     reset_n,
  input  wire logic     step,
  input  wire logic     tms,
  output jcp_tap_state_t state,
  output jcp_tap_state_t state_next
);
  jcp_tap_state_t state_reg;
  jcp_tap_state_t nxt;

  always_comb begin
    case (state_reg)
      ST_TLR:   nxt = tms ? ST_TLR   : ST_RTI;
      ST_RTI:   nxt = tms ? ST_SELDR : ST_RTI;
      ST_SELDR: nxt = tms ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: nxt = tms ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  nxt = tms ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: nxt = tms ? ST_UPDR  : ST_PDR;
      ST_PDR:   nxt = tms ? ST_EX2DR : ST_PDR;
      ST_EX2DR: nxt = tms ? ST_UPDR  : ST_SHDR;
      ST_UPDR:  nxt = tms ? ST_SELDR : ST_RTI;
      ST_SELIR: nxt = tms ? ST_TLR   : ST_CAPIR;
      ST_CAPIR: nxt = tms ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  nxt = tms ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: nxt = tms ? ST_UPIR  : ST_PIR;
      ST_PIR:   nxt = tms ? ST_EX2IR : ST_PIR;
      ST_EX2IR: nxt = tms ? ST_UPIR  : ST_SHIR;
      ST_UPIR:  nxt = tms ? ST_SELDR : ST_RTI;
      default:  nxt = ST_TLR;
    endcase
  end

  // power-on state is test-logic-reset
  always_ff @(posedge clk) begin
    if (!reset_n) state_reg <= ST_TLR;
    else if (step) state_reg <= nxt;
  end

  assign state      = state_reg;
  assign state_next = nxt;

  tlr_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (step && tms && state_reg == ST_TLR) |=> state_reg == ST_TLR)
    else $error("reset state left while tms high");
endmodule : jcp_tap_fsm

// ### hw/jcp_top.sv
// configuration test port: tap, instruction and data registers, nv ops
// Function
// - sample tms/tdi on tck rise, tdo on fall
// - standard sixteen-state tap controller
// - five tms-high clocks reach test-logic-reset
// - power-on in reset, idcode selected
// - capture-dr loads bypass and idcode; configuration and converter registers keep their contents
// - capture-ir loads the idcode instruction
// - five-bit instruction register, full decode
// - configuration instruction codes 01 to 04
// - converter codes 11 to 14, calibration 10
// - all ones selects the bypass bit
// - extest and sample act as bypass
// - idcode shifts 32-bit identification word
// - select routes shift-dr through configuration register
// - configuration shift register is 109 bits
// - program writes nv on idle entry, suspends
// - verify copies nv into shift register
// - converter instructions mirror configuration ones, without parking outputs
// - calibration on idle entry, outputs zero, autonomous
// - erase clears bits; program only sets
// - selects in update-ir, operations on idle entry
// - bypass is one single-bit shift stage
`timescale 1ns/1ns
module jcp_top import jcp_pkg::*; #(
  parameter logic [ID_W-1:0] ID_VALUE  = 32'h0A5A_5001, // arbitrary value
  parameter int              CONV_BITS = CONV_W,
  parameter int              PROG_CYC  = PROG_CYC_DEF,
  parameter int              ERASE_CYC = ERASE_CYC_DEF,
  parameter int              CAL_CYC   = CAL_CYC_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire jcp_pins_t            pins,
  output logic                      tdo,
  output logic                      tdo_oe,
  output logic                      busy,
  output jcp_analog_t               analog,
  output logic [CFG_W-1:0]          cfg_bits,
  output logic [CONV_BITS-1:0]      conv_bits
);
  jcp_pins_t            pins_s;
  jcp_tap_state_t       state;
  jcp_tap_state_t       state_next;
  jcp_op_t              op_reg;
  logic                 tck_prev_reg;
  logic [IR_W-1:0]      ir_reg;
  logic [IR_W-1:0]      ir_shift_reg;
  logic                 bypass_reg;
  logic [ID_W-1:0]      id_shift_reg;
  logic [CFG_W-1:0]     cfg_shift_reg;
  logic [CFG_W-1:0]     cfg_nv_reg;
  logic [CONV_BITS-1:0] conv_shift_reg;
  logic [CONV_BITS-1:0] conv_nv_reg;
  logic [31:0]          timer_reg;
  logic                 tdo_reg;
  logic                 tdo_oe_reg;
  logic                 vcom_reg;
  logic [2:0]           tms_cnt_reg;

  // all pins pass two flops before use
  jcp_sync #(.W($bits(jcp_pins_t))) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (pins),
    .q       (pins_s)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) tck_prev_reg <= 1'b0;
    else tck_prev_reg <= pins_s.tck;
  end

  wire tck_rise = pins_s.tck & ~tck_prev_reg;
  wire tck_fall = ~pins_s.tck & tck_prev_reg;

  jcp_tap_fsm u_fsm (
    .clk        (clk),
    .reset_n    (reset_n),
    .step       (tck_rise),
    .tms        (pins_s.tms),
    .state      (state),
    .state_next (state_next)
  );

  // state decode; strobes qualified by the sampling edge, update-ir by the fall
  wire in_shdr   = state == ST_SHDR;
  wire in_shir   = state == ST_SHIR;
  wire in_shift  = in_shdr | in_shir;
  wire cap_dr    = tck_rise & (state == ST_CAPDR);
  wire sh_dr     = tck_rise & in_shdr;
  wire cap_ir    = tck_rise & (state == ST_CAPIR);
  wire sh_ir     = tck_rise & in_shir;
  // update-ir acts at the fall, so idle entry already sees the new code
  wire upd_ir    = tck_fall & (state == ST_UPIR);
  wire rti_entry = tck_rise & (state_next == ST_RTI) & (state != ST_RTI);

  // data path selection from the five-bit instruction
  wire sel_id   = ir_reg == IR_IDCODE;
  wire sel_cfg  = (ir_reg == IR_SEL_CFG) | (ir_reg == IR_CFG_PROG) |
                  (ir_reg == IR_CFG_VERIFY);
  wire sel_conv = (ir_reg == IR_SEL_CONV) | (ir_reg == IR_CONV_PROG) |
                  (ir_reg == IR_CONV_VERIFY);
  // extest, sample, bypass and any other code use the bypass bit
  wire sel_byp  = ~(sel_id | sel_cfg | sel_conv);

  // operations start only on idle entry and while idle of work
  wire op_go          = rti_entry & (op_reg == OP_NONE);
  wire cfg_prog_go    = op_go & (ir_reg == IR_CFG_PROG);
  wire cfg_erase_go   = op_go & (ir_reg == IR_CFG_ERASE);
  wire cfg_verify_go  = op_go & (ir_reg == IR_CFG_VERIFY);
  wire conv_prog_go   = op_go & (ir_reg == IR_CONV_PROG);
  wire conv_erase_go  = op_go & (ir_reg == IR_CONV_ERASE);
  wire conv_verify_go = op_go & (ir_reg == IR_CONV_VERIFY);
  wire cal_go         = op_go & (ir_reg == IR_CAL_START);
  wire prog_go        = cfg_prog_go | conv_prog_go;
  wire erase_go       = cfg_erase_go | conv_erase_go;
  wire timer_done     = (op_reg != OP_NONE) & (timer_reg == 32'h0);

  wire tdo_mux = in_shir  ? ir_shift_reg[0]   :
                 sel_id   ? id_shift_reg[0]   :
                 sel_cfg  ? cfg_shift_reg[0]  :
                 sel_conv ? conv_shift_reg[0] : bypass_reg;

  // instruction register, idcode in reset state
  always_ff @(posedge clk) begin
    if (!reset_n || state == ST_TLR) ir_reg <= IR_IDCODE;
    else if (upd_ir) ir_reg <= ir_shift_reg;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) ir_shift_reg <= IR_IDCODE;
    else if (cap_ir) ir_shift_reg <= IR_IDCODE;
    else if (sh_ir) ir_shift_reg <= {pins_s.tdi, ir_shift_reg[IR_W-1:1]};
  end

  always_ff @(posedge clk) begin
    if (!reset_n) bypass_reg <= 1'b0;
    else if (cap_dr && sel_byp) bypass_reg <= 1'b0;
    else if (sh_dr && sel_byp) bypass_reg <= pins_s.tdi;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) id_shift_reg <= '0;
    else if (cap_dr && sel_id) id_shift_reg <= ID_VALUE;
    else if (sh_dr && sel_id) id_shift_reg <= {pins_s.tdi, id_shift_reg[ID_W-1:1]};
  end

  // capture keeps the contents so verified data survives to the scan
  always_ff @(posedge clk) begin
    if (!reset_n) cfg_shift_reg <= '0;
    else if (cfg_verify_go) cfg_shift_reg <= cfg_nv_reg;
    else if (sh_dr && sel_cfg)
      cfg_shift_reg <= {pins_s.tdi, cfg_shift_reg[CFG_W-1:1]};
  end

  always_ff @(posedge clk) begin
    if (!reset_n) conv_shift_reg <= '0;
    else if (conv_verify_go) conv_shift_reg <= conv_nv_reg;
    else if (sh_dr && sel_conv)
      conv_shift_reg <= {pins_s.tdi, conv_shift_reg[CONV_BITS-1:1]};
  end

  // nonvolatile store: erase clears, program only sets bits
  always_ff @(posedge clk) begin
    if (!reset_n) cfg_nv_reg <= '0;
    else if (cfg_erase_go) cfg_nv_reg <= '0;
    else if (cfg_prog_go) cfg_nv_reg <= cfg_nv_reg | cfg_shift_reg;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) conv_nv_reg <= '0;
    else if (conv_erase_go) conv_nv_reg <= '0;
    else if (conv_prog_go) conv_nv_reg <= conv_nv_reg | conv_shift_reg;
  end

  // erased configuration parks outputs at mid-rail, inputs open
  always_ff @(posedge clk) begin
    if (!reset_n) vcom_reg <= 1'b0;
    else if (cfg_erase_go) vcom_reg <= 1'b1;
    else if (cfg_prog_go) vcom_reg <= 1'b0;
  end

  // operation timer runs on clk alone; tap activity cannot stop it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      op_reg    <= OP_NONE;
      timer_reg <= 32'h0;
    end else if (prog_go) begin
      op_reg    <= OP_PROG;
      timer_reg <= 32'(PROG_CYC - 1);
    end else if (erase_go) begin
      op_reg    <= OP_ERASE;
      timer_reg <= 32'(ERASE_CYC - 1);
    end else if (cal_go) begin
      op_reg    <= OP_CAL;
      timer_reg <= 32'(CAL_CYC - 1);
    end else if (timer_done) begin
      op_reg    <= OP_NONE;
    end else if (op_reg != OP_NONE) begin
      timer_reg <= timer_reg - 32'h1;
    end
  end

  // tdo and its enable move only on the falling edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_reg    <= tdo_mux;
      tdo_oe_reg <= in_shift;
    end
  end

  assign tdo                 = tdo_reg;
  assign tdo_oe              = tdo_oe_reg;
  assign busy                = op_reg != OP_NONE;
  // one driver for the whole struct
  assign analog              = '{
    outputs_zero: op_reg == OP_CAL,
    outputs_vcom: vcom_reg,
    inputs_off:   vcom_reg,
    suspend:      (op_reg == OP_PROG) | (op_reg == OP_ERASE)
  };
  assign cfg_bits            = cfg_nv_reg;
  assign conv_bits           = conv_nv_reg;

  // helper: consecutive tms-high rises, saturating
  always_ff @(posedge clk) begin
    if (!reset_n) tms_cnt_reg <= 3'h0;
    else if (tck_rise && !pins_s.tms) tms_cnt_reg <= 3'h0;
    else if (tck_rise && tms_cnt_reg != TLR_STEPS) tms_cnt_reg <= tms_cnt_reg + 3'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  tlr_five_a: assert property (
    tms_cnt_reg == TLR_STEPS |-> state == ST_TLR)
    else $error("tap not in reset after five tms-high clocks");

  tdo_edge_a: assert property (
    $changed(tdo_reg) |-> $past(tck_fall))
    else $error("tdo changed away from a falling tck");

  oe_shift_a: assert property (
    tck_fall |=> tdo_oe_reg == $past(in_shift))
    else $error("tdo enable does not follow shift state");

  capir_id_a: assert property (
    cap_ir |=> ir_shift_reg == IR_IDCODE)
    else $error("capture-ir did not load idcode");

  upir_load_a: assert property (
    upd_ir |=> ir_reg == $past(ir_shift_reg))
    else $error("update-ir did not load instruction");

  reset_ir_a: assert property (
    state == ST_TLR |=> ir_reg == IR_IDCODE)
    else $error("idcode not selected in reset state");

  byp_stage_a: assert property (
    (sh_dr && sel_byp) |=> bypass_reg == $past(pins_s.tdi) ##0 sel_byp)
    else $error("bypass stage did not take tdi");

  idcap_a: assert property (
    (cap_dr && sel_id) |=> id_shift_reg == ID_VALUE)
    else $error("capture-dr did not load identification word");

  nv_clear_a: assert property (
    |($past(cfg_nv_reg) & ~cfg_nv_reg) |-> $past(cfg_erase_go))
    else $error("configuration bit cleared without erase");

  verify_a: assert property (
    cfg_verify_go |=> cfg_shift_reg == $past(cfg_nv_reg))
    else $error("verify did not copy stored configuration");

  cal_zero_a: assert property (
    cal_go |=> analog.outputs_zero && busy)
    else $error("calibration did not force outputs to zero");

  busy_start_a: assert property (
    $rose(busy) |-> $past(rti_entry))
    else $error("operation started outside idle entry");

  tap_hold_a: assert property (
    !tck_rise |=> state == $past(state))
    else $error("tap state moved without a tck rise");

  ir_shift_a: assert property (
    sh_ir |=> ir_shift_reg == {$past(pins_s.tdi), $past(ir_shift_reg[IR_W-1:1])})
    else $error("instruction shift lost a bit");

  byp_cap_a: assert property (
    (cap_dr && sel_byp) |=> bypass_reg == 1'b0)
    else $error("bypass capture did not load zero");

  byp_out_a: assert property (
    (tck_fall && in_shdr && sel_byp) |=> tdo_reg == $past(bypass_reg))
    else $error("bypass bit not presented on tdo");

  id_shift_a: assert property (
    (sh_dr && sel_id) |=> id_shift_reg[ID_W-1] == $past(pins_s.tdi))
    else $error("identification shift lost tdi");

  cfg_shift_a: assert property (
    (sh_dr && sel_cfg) |=>
      cfg_shift_reg == {$past(pins_s.tdi), $past(cfg_shift_reg[CFG_W-1:1])})
    else $error("configuration shift lost a bit");

  prog_set_a: assert property (
    cfg_prog_go |=> cfg_nv_reg == ($past(cfg_nv_reg) | $past(cfg_shift_reg)))
    else $error("program did not merge shifted bits");

  prog_susp_a: assert property (
    prog_go |=> analog.suspend && busy && !analog.outputs_zero)
    else $error("program did not suspend operation");

  erase_zero_a: assert property (
    cfg_erase_go |=> cfg_nv_reg == '0 && analog.outputs_vcom && analog.inputs_off)
    else $error("erase did not clear store and park outputs");

  conv_prog_a: assert property (
    conv_prog_go |=> conv_nv_reg == ($past(conv_nv_reg) | $past(conv_shift_reg)))
    else $error("converter program did not set bits");

  conv_erase_a: assert property (
    conv_erase_go |=> conv_nv_reg == '0 && cfg_nv_reg == $past(cfg_nv_reg))
    else $error("converter erase touched the wrong store");

  conv_ver_a: assert property (
    conv_verify_go |=> conv_shift_reg == $past(conv_nv_reg))
    else $error("converter verify did not copy store");

  cal_free_a: assert property (
    (op_reg == OP_CAL && timer_reg != 32'h0) |=> op_reg == OP_CAL)
    else $error("calibration ended early");

  busy_refuse_a: assert property (
    (rti_entry && busy) |=> op_reg == $past(op_reg) || op_reg == OP_NONE)
    else $error("new operation accepted while busy");

  prog_cov: cover property (cfg_prog_go);
  cal_cov: cover property (cal_go ##1 busy);
  id_scan_cov: cover property (sh_dr && sel_id);
  conv_cov: cover property (conv_verify_go);
endmodule : jcp_top

// ### verification/jcp_ctl_model.sv
// test controller model that drives the configuration port pins
`timescale 1ns/1ns
module jcp_ctl_model import jcp_pkg::*; (
  input  wire logic clk,
  input  wire logic tdo,
  input  wire logic tdo_oe,
  output jcp_pins_t pins
);
  initial pins = '0;

  // one tck period is 8 clk; tms and tdi move only at the fall
  task automatic tck_cycle(input logic m, input logic d, output logic o);
    @(posedge clk);
    pins <= {1'b0, m, d};
    repeat (4) @(posedge clk);
    pins.tck <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    o = tdo;
  endtask : tck_cycle

  task automatic idle(input int n);
    logic b;
    for (int i = 0; i < n; i++) tck_cycle(1'b0, 1'b0, b);
  endtask : idle

  // tck stands high afterwards, with the tap parked
  task automatic reset_tap(input logic to_idle);
    logic b;
    repeat (5) tck_cycle(1'b1, 1'b0, b);
    if (to_idle) tck_cycle(1'b0, 1'b0, b);
  endtask : reset_tap

  // scan from run-test/idle back to run-test/idle, lsb first
  task automatic scan(input logic is_ir, input logic [CFG_W-1:0] din, input int n,
                      output logic [CFG_W-1:0] dout, output logic oe_ok);
    logic b;
    dout  = '0;
    oe_ok = 1'b1;
    tck_cycle(1'b1, 1'b0, b);
    if (is_ir) tck_cycle(1'b1, 1'b0, b);
    tck_cycle(1'b0, 1'b0, b);
    tck_cycle(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tck_cycle(i == n - 1, din[i], b);
      dout[i] = b;
      if (tdo_oe !== 1'b1) oe_ok = 1'b0;
    end
    tck_cycle(1'b1, 1'b0, b);
    if (tdo_oe !== 1'b0) oe_ok = 1'b0;
    tck_cycle(1'b0, 1'b0, b);
  endtask : scan
endmodule : jcp_ctl_model

// ### verification/tb_top.sv
// testbench for the configuration test port
`timescale 1ns/1ns
module tb_top import jcp_pkg::*; ;
  localparam logic [ID_W-1:0] ID = 32'h0A5A_5001; // arbitrary value
  localparam int N_OP = 20;
  localparam int N_CAL = 30;

  logic                clk = 1'b0;
  logic                reset_n = 1'b0;
  jcp_pins_t           pins;
  logic                tdo;
  logic                tdo_oe;
  logic                busy;
  jcp_analog_t         analog;
  logic [CFG_W-1:0]    cfg_bits;
  logic [CONV_W-1:0]   conv_bits;
  int                  mismatches = 0;
  int                  n_compared = 0;

  always #2 clk = ~clk;

  jcp_top #(.ID_VALUE(ID), .CONV_BITS(CONV_W), .PROG_CYC(N_OP), .ERASE_CYC(N_OP),
            .CAL_CYC(N_CAL)) DUT (
    .clk(clk), .reset_n(reset_n), .pins(pins), .tdo(tdo), .tdo_oe(tdo_oe), .busy(busy),
    .analog(analog), .cfg_bits(cfg_bits), .conv_bits(conv_bits));

  jcp_ctl_model u_ctl (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .pins(pins));

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic check(input logic [CFG_W-1:0] seen, input logic [CFG_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic ir(input logic [IR_W-1:0] code);
    logic [CFG_W-1:0] o;
    logic ok;
    u_ctl.scan(1'b1, code, IR_W, o, ok);
    check(o, 5'h0D);
    check(ok, 1'b1);
  endtask : ir

  task automatic dr(input logic [CFG_W-1:0] din, input int n, output logic [CFG_W-1:0] o);
    logic ok;
    u_ctl.scan(1'b0, din, n, o, ok);
    check(ok, 1'b1);
  endtask : dr

  // tck stands still while the operation runs on its own
  task automatic wait_idle(input int bound);
    int cnt;
    cnt = 0;
    while (busy !== 1'b0 && cnt < bound) begin
      @(posedge clk);
      cnt++;
    end
    if (cnt >= bound) begin
      mismatches++;
      $display("CHECK FAILED at %0t: busy stuck", $time);
      finish_test();
    end
  endtask : wait_idle

  task automatic t_idcode;
    logic [CFG_W-1:0] o;
    check(tdo_oe, 1'b0);
    u_ctl.idle(1);
    dr('0, ID_W, o);
    check(o, ID);
  endtask : t_idcode

  task automatic t_bypass;
    logic [IR_W-1:0] codes [4];
    logic [CFG_W-1:0] o;
    codes = '{IR_BYPASS, IR_EXTEST, IR_SAMPLE, 5'h0F};
    foreach (codes[i]) begin
      ir(codes[i]);
      dr(2'h3, 2, o);
      check(o, 2'h2);
    end
    ir(IR_IDCODE);
    dr('0, ID_W, o);
    check(o, ID);
  endtask : t_bypass

  // five tms-high clocks from shift-ir, the deepest path
  task automatic t_tap_reset;
    logic [CFG_W-1:0] o;
    logic b;
    ir(IR_BYPASS);
    u_ctl.tck_cycle(1'b1, 1'b0, b);
    u_ctl.tck_cycle(1'b1, 1'b0, b);
    u_ctl.tck_cycle(1'b0, 1'b0, b);
    u_ctl.tck_cycle(1'b0, 1'b1, b);
    u_ctl.reset_tap(1'b1);
    dr('0, ID_W, o);
    check(o, ID);
  endtask : t_tap_reset

  task automatic t_cfg;
    logic [CFG_W-1:0] o, p, q;
    p = {1'b1, {4{27'h2A5_5A5A}}};
    q = {1'b0, {4{27'h0F0_F00F}}};
    ir(IR_CFG_ERASE);
    check(busy, 1'b1);
    check(analog, 4'h7);
    check(cfg_bits, '0);
    wait_idle(N_OP + 8);
    check(analog, 4'h6);
    ir(IR_SEL_CFG);
    dr(p, CFG_W, o);
    check(cfg_bits, '0);
    ir(IR_CFG_PROG);
    check(busy, 1'b1);
    check(analog, 4'h1);
    check(cfg_bits, p);
    wait_idle(N_OP + 8);
    ir(IR_SEL_CFG);
    dr(q, CFG_W, o);
    ir(IR_CFG_PROG);
    u_ctl.reset_tap(1'b1);
    dr('0, ID_W, o);
    check(o, ID);
    check(cfg_bits, p | q);
    ir(IR_CFG_VERIFY);
    check(busy, 1'b0);
    ir(IR_SEL_CFG);
    dr('0, CFG_W, o);
    check(o, p | q);
  endtask : t_cfg

  task automatic t_conv;
    logic [CFG_W-1:0] o, keep;
    keep = cfg_bits;
    ir(IR_SEL_CONV);
    dr(8'hA7, CONV_W, o);
    ir(IR_CONV_PROG);
    wait_idle(N_OP + 8);
    check(conv_bits, 8'hA7);
    dr('0, CONV_W, o);
    check(o, 8'hA7);
    ir(IR_CONV_VERIFY);
    ir(IR_SEL_CONV);
    dr('0, CONV_W, o);
    check(o, 8'hA7);
    ir(IR_CONV_ERASE);
    wait_idle(N_OP + 8);
    check(conv_bits, '0);
    check(cfg_bits, keep);
    check(analog, 4'h0);
  endtask : t_conv

  task automatic t_cal;
    ir(IR_CAL_START);
    check(busy, 1'b1);
    check(analog, 4'h8);
    wait_idle(N_CAL + 8);
    check(analog, 4'h0);
  endtask : t_cal

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_idcode();
    t_bypass();
    t_tap_reset();
    t_cfg();
    t_conv();
    t_cal();
    u_ctl.reset_tap(1'b0);
    check(tdo_oe, 1'b0);
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    $display("CHECK FAILED at %0t: run too long", $time);
    finish_test();
  end
endmodule : tb_top
